//--- logic/ubrg_pkg.sv
// Package: offsets, fields, reset values and mode carrier of the baud generator
package ubrg_pkg;
  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] UBRG_OFS_TX_CTRL = 8'h00;
  localparam logic [7:0] UBRG_OFS_RX_CTRL = 8'h04;
  localparam logic [7:0] UBRG_OFS_BAUD_CTRL = 8'h08;
  localparam logic [7:0] UBRG_OFS_DIV_HIGH = 8'h0C;
  localparam logic [7:0] UBRG_OFS_DIV_LOW = 8'h10;
  localparam logic [7:0] UBRG_OFS_STATUS = 8'h14;
  // ****************************************
  // Reset values and writable masks
  // ****************************************
  localparam logic [7:0] UBRG_RST_TX_CTRL = 8'h00;
  localparam logic [7:0] UBRG_RST_RX_CTRL = 8'h00;
  localparam logic [7:0] UBRG_RST_BAUD_CTRL = 8'h00;
  localparam logic [7:0] UBRG_RST_DIV = 8'h00;
  localparam logic [7:0] UBRG_WMASK_TX = 8'hFD;
  localparam logic [7:0] UBRG_WMASK_RX = 8'hF9;
  localparam logic [7:0] UBRG_WMASK_BAUD = 8'h9B;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int UBRG_TX_CLK_MASTER = 7;
  localparam int UBRG_TX_SYNC = 4;
  localparam int UBRG_TX_HIGH_SPEED = 2;
  localparam int UBRG_TX_SHIFT_EMPTY = 1;
  localparam int UBRG_RX_PORT_ENABLE = 7;
  localparam int UBRG_BAUD_RX_IDLE = 6;
  localparam int UBRG_BAUD_WIDE = 3;
  // ****************************************
  // Division factors and sampler reset value
  // ****************************************
  localparam logic [6:0] UBRG_FAC_LOW = 7'h40;
  localparam logic [6:0] UBRG_FAC_HIGH = 7'h10;
  localparam logic [6:0] UBRG_FAC_SYNC = 7'h04;
  localparam logic [2:0] UBRG_SMP_RST = 3'h7;
  // ****************************************
  // Mode carrier
  // ****************************************
  typedef struct packed {
    logic enable;
    logic sync;
    logic master;
    logic high_speed;
    logic wide;
  } ubrg_mode_t;
endpackage

//--- logic/ubrg_timer.sv
// Free-running reload timer of the baud generator
`timescale 1ns/10ps
`default_nettype none
module ubrg_timer #(
  parameter int WIDTH = 16
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic clear_i,
  input wire logic [WIDTH-1:0] limit_i,
  output logic tick_o
);
  // ****************************************
  // Counter
  // ****************************************
  logic [WIDTH-1:0] cnt_q, cnt_d;
  logic tick_q, tick_d;
  logic wrap;

  always_comb begin
    wrap = (cnt_q >= limit_i);
    tick_d = wrap && !clear_i;
    if (clear_i) begin
      cnt_d = '0;
    end else if (wrap) begin
      cnt_d = '0;
    end else begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick_o = tick_q;

  // ****************************************
  // Checks
  // ****************************************
  a_clear_zeroes: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    clear_i |=> (cnt_q == '0) && !tick_q)
    else $error("timer not cleared");
  a_wrap_reload: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    tick_q |-> (cnt_q == '0) && ($past(cnt_q) >= $past(limit_i)))
    else $error("timer tick without wrap");
endmodule
`default_nettype wire

//--- logic/ubrg_top.sv
// Baud rate generator with register file and receive-line majority sampler
//
// Behaviour
// - Bit timing counts the system clock directly
// - Three receive samples, majority decides level
// - Divisor is high byte above low byte
// - Async, narrow, low speed divides by 64(n+1)
// - Divisor held in two writable bytes
// - Unimplemented bits read zero, ignore writes
// - Divisor write clears the generator timer
// - Narrow default uses low byte only
// - Synchronous mode ignores high speed select
// - Synchronous slave stops the internal generator
`timescale 1ns/10ps
`default_nettype none
module ubrg_top #(
  parameter int ADDR_W = 8
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic rx_pin_i,
  output logic bit_tick_o,
  output logic rx_level_o,
  output logic sample_done_o
);
  import ubrg_pkg::*;

  // ****************************************
  // Register file over APB
  // ****************************************
  logic [7:0] tx_q, tx_d, rx_q, rx_d, baud_q, baud_d, divh_q, divh_d, divl_q, divl_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic access, wr_en, div_wr, mapped;
  logic [7:0] addr8, rdata8;
  logic rx_level_q, rx_level_d;
  ubrg_mode_t mode;

  always_comb begin
    addr8 = paddr_i[7:0];
    access = psel_i && penable_i;
    wr_en = access && pready_q && pwrite_i;
    mapped = 1'b1;
    rdata8 = 8'h00;
    case (addr8)
      UBRG_OFS_TX_CTRL: begin
        rdata8 = (tx_q & UBRG_WMASK_TX) | (8'h01 << UBRG_TX_SHIFT_EMPTY);
      end
      UBRG_OFS_RX_CTRL: begin
        rdata8 = rx_q & UBRG_WMASK_RX;
      end
      UBRG_OFS_BAUD_CTRL: begin
        rdata8 = (baud_q & UBRG_WMASK_BAUD) | ({7'h00, rx_level_q} << UBRG_BAUD_RX_IDLE);
      end
      UBRG_OFS_DIV_HIGH: begin
        rdata8 = divh_q;
      end
      UBRG_OFS_DIV_LOW: begin
        rdata8 = divl_q;
      end
      UBRG_OFS_STATUS: begin
        rdata8 = {6'h00, mode.sync && !mode.master, rx_level_q};
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
    pready_d = access && !pready_q;
    pslverr_d = access && !pready_q && !mapped;
    prdata_d = (access && !pready_q && !pwrite_i) ? {24'h000000, rdata8} : 32'h00000000;
    tx_d = tx_q;
    rx_d = rx_q;
    baud_d = baud_q;
    divh_d = divh_q;
    divl_d = divl_q;
    div_wr = 1'b0;
    if (wr_en) begin
      case (addr8)
        UBRG_OFS_TX_CTRL: begin
          tx_d = pwdata_i[7:0] & UBRG_WMASK_TX;
        end
        UBRG_OFS_RX_CTRL: begin
          rx_d = pwdata_i[7:0] & UBRG_WMASK_RX;
        end
        UBRG_OFS_BAUD_CTRL: begin
          baud_d = pwdata_i[7:0] & UBRG_WMASK_BAUD;
        end
        UBRG_OFS_DIV_HIGH: begin
          divh_d = pwdata_i[7:0];
          div_wr = 1'b1;
        end
        UBRG_OFS_DIV_LOW: begin
          divl_d = pwdata_i[7:0];
          div_wr = 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      tx_q <= UBRG_RST_TX_CTRL;
      rx_q <= UBRG_RST_RX_CTRL;
      baud_q <= UBRG_RST_BAUD_CTRL;
      divh_q <= UBRG_RST_DIV;
      divl_q <= UBRG_RST_DIV;
      prdata_q <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      tx_q <= tx_d;
      rx_q <= rx_d;
      baud_q <= baud_d;
      divh_q <= divh_d;
      divl_q <= divl_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ****************************************
  // Mode decode
  // ****************************************
  logic [15:0] divisor;
  logic [6:0] factor;
  logic gen_run, gen_clear, gen_tick;

  always_comb begin
    mode.enable = rx_q[UBRG_RX_PORT_ENABLE];
    mode.sync = tx_q[UBRG_TX_SYNC];
    mode.master = tx_q[UBRG_TX_CLK_MASTER];
    mode.high_speed = tx_q[UBRG_TX_HIGH_SPEED];
    mode.wide = baud_q[UBRG_BAUD_WIDE];
    divisor = mode.wide ? {divh_q, divl_q} : {8'h00, divl_q};
    if (mode.sync) begin
      factor = UBRG_FAC_SYNC;
    end else if (mode.wide ^ mode.high_speed) begin
      factor = UBRG_FAC_HIGH;
    end else if (mode.wide && mode.high_speed) begin
      factor = UBRG_FAC_SYNC;
    end else begin
      factor = UBRG_FAC_LOW;
    end
    gen_run = mode.enable && (!mode.sync || mode.master);
    gen_clear = div_wr || !gen_run;
  end

  ubrg_timer #(
    .WIDTH(16)
  ) u_timer (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .clear_i(gen_clear),
    .limit_i(divisor),
    .tick_o(gen_tick)
  );

  // ****************************************
  // Bit phase counter
  // ****************************************
  logic [5:0] ph_q, ph_d, fac_last, mid;
  logic bit_tick_q, bit_tick_d;

  always_comb begin
    fac_last = 6'(factor - 7'h01);
    mid = factor[6:1];
    ph_d = ph_q;
    bit_tick_d = 1'b0;
    if (gen_clear) begin
      ph_d = 6'h00;
    end else if (gen_tick) begin
      if (ph_q >= fac_last) begin
        ph_d = 6'h00;
        bit_tick_d = 1'b1;
      end else begin
        ph_d = ph_q + 6'h01;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ph_q <= 6'h00;
      bit_tick_q <= 1'b0;
    end else begin
      ph_q <= ph_d;
      bit_tick_q <= bit_tick_d;
    end
  end

  // ****************************************
  // Receive pin sync and majority vote
  // ****************************************
  logic rx_meta_q, rx_sync_q;
  logic [2:0] smp_q, smp_d;
  logic done_q, done_d, smp_en, vote_en;

  always_comb begin
    smp_en = gen_tick && !gen_clear && (ph_q >= mid - 6'h01) && (ph_q <= mid + 6'h01);
    vote_en = gen_tick && !gen_clear && (ph_q == mid + 6'h01);
    smp_d = smp_en ? {smp_q[1:0], rx_sync_q} : smp_q;
    rx_level_d = rx_level_q;
    done_d = 1'b0;
    if (vote_en) begin
      rx_level_d = (smp_d[0] & smp_d[1]) | (smp_d[1] & smp_d[2]) | (smp_d[0] & smp_d[2]);
      done_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
      smp_q <= UBRG_SMP_RST;
      rx_level_q <= 1'b1;
      done_q <= 1'b0;
    end else begin
      rx_meta_q <= rx_pin_i;
      rx_sync_q <= rx_meta_q;
      smp_q <= smp_d;
      rx_level_q <= rx_level_d;
      done_q <= done_d;
    end
  end

  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign bit_tick_o = bit_tick_q;
  assign rx_level_o = rx_level_q;
  assign sample_done_o = done_q;

  // ****************************************
  // Checks
  // ****************************************
  sequence s_wrap_tick;
    gen_tick && !gen_clear && (ph_q >= fac_last);
  endsequence

  a_phase_wrap: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    s_wrap_tick |=> bit_tick_q ##1 !bit_tick_q)
    else $error("bit tick missing after phase wrap");
  a_low_factor: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (!mode.sync && !mode.wide && !mode.high_speed) |-> (factor == 7'h40))
    else $error("low speed factor not 64");
  a_mixed_factor: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (!mode.sync && (mode.wide != mode.high_speed)) |-> (factor == 7'h10))
    else $error("mixed select factor not 16");
  a_sync_factor: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    mode.sync |-> (factor == 7'h04))
    else $error("sync factor not 4");
  a_narrow_div: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    !mode.wide |-> (divisor == {8'h00, divl_q}))
    else $error("narrow mode uses high byte");
  a_slave_quiet: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (mode.sync && !mode.master) [*2] |-> !bit_tick_q && (ph_q == 6'h00))
    else $error("generator runs in sync slave");
  a_div_clear: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    div_wr |=> (ph_q == 6'h00) && !bit_tick_q)
    else $error("divisor write did not clear");
  a_vote_major: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    vote_en |=> (rx_level_q == ((smp_q[0] & smp_q[1]) | (smp_q[1] & smp_q[2]) | (smp_q[0] & smp_q[2]))))
    else $error("majority vote wrong");
  a_reserved_zero: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (pready_q && !pwrite_i && $past(addr8) == UBRG_OFS_BAUD_CTRL) |-> (prdata_q[5] == 1'b0) && (prdata_q[2] == 1'b0))
    else $error("reserved bit reads one");
endmodule
`default_nettype wire

//--- testbench/ubrg_line_model.sv
// Far-side serial transmitter driving the receive line
`timescale 1ns/10ps
`default_nettype none
module ubrg_line_model (
  input wire logic clk_i,
  input wire logic [1:0] mode_i,
  output logic line_o
);
  logic [1:0] ph_q = 2'h0;
  // ****************
  // Line levels
  // ****************
  always @(posedge clk_i) begin
    ph_q <= ph_q + 2'h1;
    // Idle mark, steady space, or space with one-cycle spikes
    case (mode_i)
      2'h1: line_o <= 1'b0;
      2'h2: line_o <= (ph_q == 2'h3);
      default: line_o <= 1'b1;
    endcase
  end
endmodule
`default_nettype wire

//--- testbench/ubrg_top_bench.sv
// Self-checking bench of the baud generator
`timescale 1ns/10ps
`default_nettype none
`define CHK(a,b) begin tests_run++; if ((a)!==(b)) begin errors++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module ubrg_top_bench;
  import ubrg_pkg::*;
  logic sys_clk, srst, psel, penable, pwrite, pready, pslverr, line, tick, lvl, sdone, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] lmode;
  int errors = 0;
  int tests_run = 0;
  int c;
  int cnt;
  logic [7:0] ofs [7] = '{UBRG_OFS_TX_CTRL, UBRG_OFS_RX_CTRL, UBRG_OFS_BAUD_CTRL, UBRG_OFS_DIV_HIGH,
    UBRG_OFS_DIV_LOW, UBRG_OFS_STATUS, 8'h18};
  logic [7:0] rstv [7] = '{8'h02, 8'h00, 8'h40, 8'h00, 8'h00, 8'h01, 8'h00};
  logic [7:0] ffv [7] = '{8'hFF, 8'hF9, 8'hDB, 8'hFF, 8'hFF, 8'h01, 8'h00};
  logic [7:0] mtx [6] = '{8'h00, 8'h04, 8'h00, 8'h04, 8'h90, 8'h94};
  logic [7:0] mbd [6] = '{8'h00, 8'h00, 8'h08, 8'h08, 8'h00, 8'h00};
  int mper [6] = '{64*3, 16*3, 16*259, 4*259, 4*3, 4*3};
  ubrg_top i_dut (.sys_clk_i(sys_clk), .srst_i(srst), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .rx_pin_i(line), .bit_tick_o(tick), .rx_level_o(lvl), .sample_done_o(sdone));
  ubrg_line_model i_line (.clk_i(sys_clk), .mode_i(lmode), .line_o(line));
  // ****************
  // Tasks
  // ****************
  task conclude;
    if (errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      errors++;
      conclude();
    end
  endtask
  task tick_wait;
    c = 0;
    do begin
      @(posedge sys_clk);
      c++;
    end while (tick !== 1'b1 && c < 20000);
    if (c >= 20000) begin
      errors++;
      conclude();
    end
  endtask
  // ****************
  // Sequence
  // ****************
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (100000) @(posedge sys_clk);
    errors++;
    conclude();
  end
  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    lmode = 2'h0;
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, ofs[i], 8'h00);
      `CHK(rd, {24'h0, rstv[i]})
      `CHK(err, i == 6)
      apb(1'b1, ofs[i], 8'hFF);
    end
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, ofs[i], 8'h00);
      `CHK(rd, {24'h0, ffv[i]})
    end
    apb(1'b1, UBRG_OFS_RX_CTRL, 8'h80);
    apb(1'b1, UBRG_OFS_DIV_HIGH, 8'h01);
    apb(1'b1, UBRG_OFS_DIV_LOW, 8'h02);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, UBRG_OFS_TX_CTRL, mtx[i]);
      apb(1'b1, UBRG_OFS_BAUD_CTRL, mbd[i]);
      tick_wait();
      tick_wait();
      tick_wait();
      `CHK(c, mper[i])
    end
    apb(1'b1, UBRG_OFS_TX_CTRL, 8'h00);
    apb(1'b1, UBRG_OFS_BAUD_CTRL, 8'h00);
    apb(1'b1, UBRG_OFS_DIV_LOW, 8'hFF);
    repeat (8192) @(posedge sys_clk);
    apb(1'b1, UBRG_OFS_DIV_LOW, 8'h00);
    tick_wait();
    `CHK(c >= 62 && c <= 68, 1'b1)
    apb(1'b1, UBRG_OFS_TX_CTRL, 8'h10);
    cnt = 0;
    repeat (300) begin
      @(posedge sys_clk);
      if (tick !== 1'b0) cnt++;
    end
    `CHK(cnt, 0)
    apb(1'b0, UBRG_OFS_STATUS, 8'h00);
    `CHK(rd[1], 1'b1)
    apb(1'b1, UBRG_OFS_TX_CTRL, 8'h90);
    lmode <= 2'h2;
    repeat (20) @(posedge sys_clk);
    cnt = 0;
    repeat (40) begin
      @(posedge sys_clk);
      if (sdone === 1'b1) begin
        cnt++;
        `CHK(lvl, 1'b0)
      end
    end
    `CHK(cnt > 0, 1'b1)
    apb(1'b0, UBRG_OFS_BAUD_CTRL, 8'h00);
    `CHK(rd, 32'h0)
    lmode <= 2'h0;
    repeat (20) @(posedge sys_clk);
    `CHK(lvl, 1'b1)
    conclude();
  end
endmodule
`default_nettype wire
